// file: psc_master.sv
// Serial bus master model that frames commands and captures responses
`timescale 1ns/1ps
`default_nettype none
module psc_master (
  // Clock used only to line edges up with the bench
  input wire logic clk_i,
  // Serial link
  output logic sck_o,
  output logic chip_select_low_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // Idle: deselected, serial clock parked low between frames
  initial begin
    sck_o = 1'b0;
    chip_select_low_o = 1'b1;
    sdi_o = 1'b0;
  end

  // One frame of n clocks, MSB first; extra clocks past 16 shift zeros
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk_i);
    chip_select_low_o = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      sdi_o = (i < 16) ? tx[15-i] : 1'b0;
      #100 sck_o = 1'b1;
      rx = {rx[14:0], sdo_i};
      #100 sck_o = 1'b0;
    end
    #100 chip_select_low_o = 1'b1;
    // Flip the released data line so a stale bit never looks valid
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule
`default_nettype wire

// file: psc_pkg.sv
// Shared constants and types for the serial status and command register block
package psc_pkg;
  // Command identifiers of the registers held here
  localparam logic [5:0] ID_NOP = 6'h00;
  localparam logic [5:0] ID_CLK_ERR = 6'h03;
  localparam logic [5:0] ID_LOW_POWER = 6'h11;
  localparam logic [5:0] ID_LOCK = 6'h12;
  localparam logic [5:0] ID_POWER_STAT = 6'h21;
  localparam logic [5:0] ID_INIT_RESP = 6'h3F;
  // Command codes and reset or initial values
  localparam logic [7:0] LOW_POWER_CODE = 8'hAA;
  localparam logic [7:0] LOCK_CODE = 8'h55;
  localparam logic [7:0] INIT_RESP_DATA = 8'h5A;
  localparam logic [7:0] CLK_ERR_RESET = 8'h80;
  localparam logic [7:0] POWER_STAT_RESET = 8'h00;
  // Field positions
  localparam int CLK_OVERRUN_BIT = 4;
  localparam int PS_BUCK_FAIL_BIT = 7;
  localparam int PS_REG_FAIL_BIT = 6;
  localparam int PS_BUCK_OT_BIT = 5;
  localparam int PS_LINEAR_OT_BIT = 4;
  localparam int PS_BOOST_OT_BIT = 3;
  localparam int PS_LINEAR_REG_BIT = 2;
  // Frame length in serial clock edges, and the count where it saturates
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [4:0] EDGE_CNT_MAX = 5'h11;
  localparam logic [3:0] CNT_FIELD_MAX = 4'hF;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Serial frame, most significant bit first on the wire
  typedef struct packed {
    logic odd_parity;
    logic write;
    logic [5:0] id;
    logic [7:0] data;
  } psc_frame_s;

  // Fault condition levels from the analog monitors
  typedef struct packed {
    logic buck_fail;
    logic reg_fail;
    logic buck_ot;
    logic linear_ot;
    logic boost_ot;
    logic linear_uv;
    logic linear_ov;
  } psc_fault_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } psc_state_e;
endpackage

// file: psc_regs.sv
// Serial slave with clock-count error, command and power status registers
`timescale 1ns/1ps
`default_nettype none
//Overview of operation
// - More than 16 serial clocks in a frame sets the clock overrun bit.
// - Count field holds rising edges minus one, saturating at 0xF.
// - Overrun bit and count field clear once sent to the master.
// - Writing 0xAA to 0x11 enters low power mode zero; reads give zero.
// - Buck shutdown faults set power status bit 7.
// - Internal regulator too low sets power status bit 6.
// - Buck overtemperature shutdown sets power status bit 5.
// - Linear regulator overtemperature shutdown sets power status bit 4.
// - Boost overtemperature shutdown sets power status bit 3.
// - Linear regulator under or overvoltage sets power status bit 2.
// - Buck and regulator flags clear only when gone and reported.
// - Overtemperature flags clear only when over and reported.
// - Linear regulation flag clears only with no fault and after reporting.
// - Response comes next frame with previous identifier and pre-write data.
// - Write to a read-only register acts as a read, no error.
// - Low power mode zero turns off switch driver and all rails but core.
module psc_regs (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // Serial link
  input wire logic SCK_I,
  input wire logic CHIP_SELECT_LOW_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  // Fault monitors
  input wire psc_pkg::psc_fault_s FAULT_I,
  // Mode outputs
  output logic LOW_POWER_MODE_ZERO_O,
  output logic LOCKED_O,
  output logic SWITCH_DRIVER_EN_O,
  output logic RAIL_EN_O
);
  import psc_pkg::*;

  logic [9:0] sync_s;
  logic sck_s, cs_s, sdi_s;
  psc_fault_s fault_s;
  logic sck_prev_reg, cs_prev_reg;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  psc_state_e state_reg, state_next;
  logic [15:0] rx_reg, rx_next, tx_reg, tx_next;
  logic [4:0] edge_cnt_reg, edge_cnt_next;
  logic [7:0] clk_err_reg, clk_err_next, pwr_reg, pwr_next;
  psc_frame_s resp_reg, resp_next, sent_reg, sent_next, rx_f;
  logic lpm_reg, lpm_next, lock_reg, lock_next;
  logic sdo_reg, sdo_next, oe_reg, oe_next;
  logic rail_reg, rail_next;
  logic [7:0] pwr_set, pwr_clr, read_data;
  logic [3:0] cnt_field;
  logic len_ok, par_ok, id_ok, frame_end, end_good, cmd_ok;

  // All pins and fault levels come from outside the clock domain
  // Select rests high in reset, matching its edge detector, so no false frame start follows reset
  psc_sync #(.WIDTH(10), .RESET_VALUE(10'h100)) u_sync (
    .clk_i(MCLK_I),
    .reset_n_i(RESET_N_I),
    .async_i({SCK_I, CHIP_SELECT_LOW_I, SDI_I, FAULT_I}),
    .sync_o(sync_s)
  );
  assign {sck_s, cs_s, sdi_s} = sync_s[9:7];
  assign fault_s = psc_fault_s'(sync_s[6:0]);

  // Edge detection on the synchronised link levels
  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;
  assign cs_fall = ~cs_s & cs_prev_reg;
  assign cs_rise = cs_s & ~cs_prev_reg;

  // Frame decode
  assign rx_f = psc_frame_s'(rx_reg);
  assign frame_end = cs_rise && (state_reg == ST_FRAME);
  assign len_ok = (edge_cnt_reg == FRAME_EDGES);
  assign par_ok = ^rx_reg;
  assign id_ok = (rx_f.id == ID_NOP) || (rx_f.id == ID_CLK_ERR) || (rx_f.id == ID_LOW_POWER) ||
                 (rx_f.id == ID_LOCK) || (rx_f.id == ID_POWER_STAT);
  assign end_good = frame_end && len_ok;
  assign cmd_ok = end_good && par_ok && id_ok;

  // Edge count minus one, clamped at both ends
  assign cnt_field = (edge_cnt_reg == 5'h00) ? 4'h0 :
                     (edge_cnt_reg >= FRAME_EDGES) ? CNT_FIELD_MAX : 4'(edge_cnt_reg - 5'h01);

  // Sticky fault sources; only bits 7 down to 2 live in this block
  always_comb begin
    pwr_set = 8'h00;
    pwr_set[PS_BUCK_FAIL_BIT] = fault_s.buck_fail;
    pwr_set[PS_REG_FAIL_BIT] = fault_s.reg_fail;
    pwr_set[PS_BUCK_OT_BIT] = fault_s.buck_ot;
    pwr_set[PS_LINEAR_OT_BIT] = fault_s.linear_ot;
    pwr_set[PS_BOOST_OT_BIT] = fault_s.boost_ot;
    pwr_set[PS_LINEAR_REG_BIT] = fault_s.linear_uv | fault_s.linear_ov;
  end

  // Read value of the addressed register before any write
  always_comb begin
    case (rx_f.id)
      ID_CLK_ERR: read_data = clk_err_reg;
      ID_POWER_STAT: read_data = pwr_reg;
      default: read_data = 8'h00;
    endcase
  end

  // Next-state logic for the link, registers and modes
  always_comb begin
    state_next = state_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    edge_cnt_next = edge_cnt_reg;
    clk_err_next = clk_err_reg;
    resp_next = resp_reg;
    sent_next = sent_reg;
    lpm_next = lpm_reg;
    lock_next = lock_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    pwr_clr = 8'h00;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_FRAME;
          edge_cnt_next = 5'h00;
          tx_next = resp_reg;
          sent_next = resp_reg;
          sdo_next = resp_reg[15];
          oe_next = 1'b1;
        end
      end
      ST_FRAME: begin
        if (cs_rise) begin
          state_next = ST_IDLE;
          oe_next = 1'b0;
          sdo_next = 1'b0;
          if (!len_ok) begin
            // Wrong length: record the count and answer with it next frame
            clk_err_next = CLK_ERR_RESET;
            clk_err_next[CLK_OVERRUN_BIT] = (edge_cnt_reg > FRAME_EDGES);
            clk_err_next[3:0] = cnt_field;
            resp_next = {1'b0, 1'b0, ID_CLK_ERR, clk_err_next};
          end else begin
            // Only a frame of valid length proves the previous answer arrived
            if (sent_reg.id == ID_CLK_ERR) begin
              clk_err_next = CLK_ERR_RESET;
            end
            if (sent_reg.id == ID_POWER_STAT) begin
              pwr_clr = sent_reg.data & ~pwr_set;
            end
            if (par_ok && id_ok) begin
              resp_next = {1'b0, 1'b0, rx_f.id, read_data};
              // Writes elsewhere fall through as reads
              if (rx_f.write && rx_f.id == ID_LOW_POWER && rx_f.data == LOW_POWER_CODE) begin
                lpm_next = 1'b1;
              end
              if (rx_f.write && rx_f.id == ID_LOCK && rx_f.data == LOCK_CODE) begin
                lock_next = 1'b1;
              end
            end else begin
              resp_next = rx_reg;
            end
          end
          resp_next.odd_parity = ~^resp_next[14:0];
        end else begin
          if (sck_rise) begin
            rx_next = {rx_reg[14:0], sdi_s};
            edge_cnt_next = (edge_cnt_reg == EDGE_CNT_MAX) ? edge_cnt_reg : 5'(edge_cnt_reg + 5'h01);
          end
          if (sck_fall) begin
            tx_next = {tx_reg[14:0], 1'b0};
            sdo_next = tx_reg[14];
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        oe_next = 1'b0;
      end
    endcase
    // A fault present in the clearing cycle keeps its flag
    pwr_next = (pwr_reg & ~pwr_clr) | pwr_set;
    rail_next = ~(lpm_next | lock_next);
  end

  // State registers; lock leaves only through reset
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      edge_cnt_reg <= 5'h00;
      clk_err_reg <= CLK_ERR_RESET;
      pwr_reg <= POWER_STAT_RESET;
      // Initial answer carries its odd parity from the start
      resp_reg <= {~^{1'b0, ID_INIT_RESP, INIT_RESP_DATA}, 1'b0, ID_INIT_RESP, INIT_RESP_DATA};
      sent_reg <= 16'h0000;
      lpm_reg <= 1'b0;
      lock_reg <= 1'b0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      rail_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_s;
      state_reg <= state_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      edge_cnt_reg <= edge_cnt_next;
      clk_err_reg <= clk_err_next;
      pwr_reg <= pwr_next;
      resp_reg <= resp_next;
      sent_reg <= sent_next;
      lpm_reg <= lpm_next;
      lock_reg <= lock_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      rail_reg <= rail_next;
    end
  end

  // Outputs straight from flops
  assign SDO_O = sdo_reg;
  assign SDO_OE_O = oe_reg;
  assign LOW_POWER_MODE_ZERO_O = lpm_reg;
  assign LOCKED_O = lock_reg;
  assign SWITCH_DRIVER_EN_O = rail_reg;
  assign RAIL_EN_O = rail_reg;

  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_long_end;
    frame_end && edge_cnt_reg > FRAME_EDGES;
  endsequence
  sequence s_reported_clk;
    end_good && sent_reg.id == ID_CLK_ERR;
  endsequence

  overrun_flag_a: assert property (s_long_end |=> clk_err_reg[CLK_OVERRUN_BIT] && resp_reg.id == ID_CLK_ERR)
    else $error("overrun bit not set after long frame");
  count_field_a: assert property (frame_end && !len_ok |=> clk_err_reg[3:0] == $past(cnt_field))
    else $error("count field wrong");
  clk_clear_a: assert property (s_reported_clk |=> clk_err_reg == CLK_ERR_RESET)
    else $error("clock error register not cleared after report");
  low_power_entry_a: assert property (cmd_ok && rx_f.write && rx_f.id == ID_LOW_POWER &&
    rx_f.data == LOW_POWER_CODE |=> LOW_POWER_MODE_ZERO_O && !RAIL_EN_O)
    else $error("low power command not taken");
  lock_sticky_a: assert property (LOCKED_O |=> LOCKED_O && !RAIL_EN_O)
    else $error("lock left without reset");
  buck_flag_set_a: assert property (fault_s.buck_fail |=> pwr_reg[PS_BUCK_FAIL_BIT])
    else $error("buck failure flag not set");
  linear_flag_set_a: assert property (fault_s.linear_uv || fault_s.linear_ov |=> pwr_reg[PS_LINEAR_REG_BIT])
    else $error("linear regulation flag not set");
  flag_unreported_a: assert property (pwr_reg[PS_BUCK_OT_BIT] && !(end_good && sent_reg.id == ID_POWER_STAT)
    |=> pwr_reg[PS_BUCK_OT_BIT])
    else $error("overtemperature flag cleared without report");
  response_latch_a: assert property (cmd_ok |=> resp_reg.id == $past(rx_f.id) && resp_reg.data == $past(read_data))
    else $error("response not latched from previous command");
  rail_off_a: assert property (lpm_reg |-> !RAIL_EN_O && !SWITCH_DRIVER_EN_O)
    else $error("rails on in low power mode");
endmodule
`default_nettype wire

// file: psc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
  parameter int WIDTH = 1,
  // Level each bit holds in reset; an idle-high pin must not look active after reset
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import psc_pkg::*;

  // One chain per bit; the first stage feeds only the second
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage_reg;
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage_reg <= {SYNC_STAGES{RESET_VALUE[b]}};
        end else begin
          stage_reg <= {stage_reg[SYNC_STAGES-2:0], async_i[b]};
        end
      end
      assign sync_o[b] = stage_reg[SYNC_STAGES-1];
    end
  endgenerate
endmodule
`default_nettype wire

// file: tb_psc_regs.sv
// Self-checking bench for the serial status and command registers
`timescale 1ns/1ps
`default_nettype none
module tb_psc_regs;
  import psc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic sck, chip_select_low, sdi, sdo, sdo_oe, lpm, locked, sw_en, rail_en;
  logic sdo_line;
  psc_fault_s fault = '0;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] rx;
  logic [7:0] flt_exp [7] = '{8'h04, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  logic [7:0] cnt_exp [3] = '{8'h9F, 8'h8E, 8'h80};
  int cnt_len [3] = '{17, 15, 1};

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  psc_regs i_psc_regs (
    .MCLK_I(mclk), .RESET_N_I(reset_n), .SCK_I(sck), .CHIP_SELECT_LOW_I(chip_select_low), .SDI_I(sdi),
    .SDO_O(sdo), .SDO_OE_O(sdo_oe), .FAULT_I(fault), .LOW_POWER_MODE_ZERO_O(lpm),
    .LOCKED_O(locked), .SWITCH_DRIVER_EN_O(sw_en), .RAIL_EN_O(rail_en)
  );

  // A released data line shows the inverse of the pin, so a missing enable spoils the answer
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  psc_master i_psc_master (
    .clk_i(mclk), .sck_o(sck), .chip_select_low_o(chip_select_low), .sdi_o(sdi), .sdo_i(sdo_line)
  );

  // Frame word with odd parity over all sixteen bits
  function automatic logic [15:0] mk(input logic w, input logic [5:0] id, input logic [7:0] d);
    return {~^{w, id, d}, w, id, d};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One frame; an empty name means the response is not judged
  task automatic fx(input logic [15:0] tx, input int n, input string nm, input logic [15:0] exp);
    i_psc_master.xfer(tx, n, rx);
    if (nm != "") chk(nm, rx, exp);
  endtask

  // Reset held three cycles, then the idle gap before the first frame
  task automatic do_reset();
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, well above the roughly eight thousand cycles needed
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    do_reset();
    chk("modes after reset", {12'h000, lpm, locked, sw_en, rail_en}, 16'h0003);
    chk("output enable idle", {15'h0000, sdo_oe}, 16'h0000);
    fx(mk(0, ID_POWER_STAT, 8'h00), 16, "first response", mk(0, ID_INIT_RESP, INIT_RESP_DATA));
    $display("test reset done");
    // Each fault alone: set, held while present, cleared once gone and reported
    for (int k = 0; k < 7; k++) begin
      @(negedge mclk);
      fault = psc_fault_s'(7'h01 << k);
      repeat (6) @(negedge mclk);
      fx(mk(0, ID_POWER_STAT, 8'h00), 16, "", 16'h0000);
      fx(mk(0, ID_POWER_STAT, 8'h00), 16, "status set", mk(0, ID_POWER_STAT, flt_exp[k]));
      @(negedge mclk);
      fault = '0;
      fx(mk(0, ID_POWER_STAT, 8'h00), 16, "status held", mk(0, ID_POWER_STAT, flt_exp[k]));
      fx(mk(0, ID_POWER_STAT, 8'h00), 16, "", 16'h0000);
      fx(mk(0, ID_POWER_STAT, 8'h00), 16, "status cleared", mk(0, ID_POWER_STAT, 8'h00));
    end
    $display("test power status done");
    // Wrong frame lengths, reported through a write to a read-only register
    for (int j = 0; j < 3; j++) begin
      fx(mk(0, ID_NOP, 8'h00), cnt_len[j], "", 16'h0000);
      fx(mk(1, ID_CLK_ERR, 8'hFF), 16, "clock count", mk(0, ID_CLK_ERR, cnt_exp[j]));
      fx(mk(0, ID_CLK_ERR, 8'h00), 16, "write as read", mk(0, ID_CLK_ERR, cnt_exp[j]));
      fx(mk(0, ID_NOP, 8'h00), 16, "clock count cleared", mk(0, ID_CLK_ERR, CLK_ERR_RESET));
    end
    $display("test clock count done");
    // Bad parity and wrong codes change no mode; the right codes do
    fx(mk(1, ID_LOCK, LOCK_CODE) ^ 16'h8000, 16, "", 16'h0000);
    fx(mk(1, ID_LOW_POWER, 8'h12), 16, "bad parity echo", mk(1, ID_LOCK, LOCK_CODE));
    chk("wrong codes ignored", {12'h000, lpm, locked, sw_en, rail_en}, 16'h0003);
    fx(mk(1, 6'h2A, LOW_POWER_CODE), 16, "wrong code reads zero", mk(0, ID_LOW_POWER, 8'h00));
    chk("unknown id ignored", {12'h000, lpm, locked, sw_en, rail_en}, 16'h0003);
    fx(mk(1, ID_LOW_POWER, LOW_POWER_CODE), 16, "unknown id echo", mk(1, 6'h2A, LOW_POWER_CODE));
    chk("low power mode", {12'h000, lpm, locked, sw_en, rail_en}, 16'h0008);
    fx(mk(1, ID_LOCK, LOCK_CODE), 16, "low power reads zero", mk(0, ID_LOW_POWER, 8'h00));
    fx(mk(0, ID_NOP, 8'h00), 16, "lock reads zero", mk(0, ID_LOCK, 8'h00));
    chk("locked mode", {12'h000, lpm, locked, sw_en, rail_en}, 16'h000C);
    do_reset();
    chk("modes after second reset", {12'h000, lpm, locked, sw_en, rail_en}, 16'h0003);
    $display("test modes done");
    wrap_up();
  end
endmodule
`default_nettype wire
